// >>> core/uart_consts.svh
// Register offsets, field positions, reset values and timing counts of the serial core
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH

`define OFF_DATA 32'h0000_0000
`define OFF_STATUS 32'h0000_0004
`define OFF_CTRL 32'h0000_0008
`define OFF_FORMAT 32'h0000_000C
`define OFF_DIVISOR 32'h0000_0010
`define OFF_INT_STATUS 32'h0000_0014
`define OFF_INT_MASK 32'h0000_0018
`define OFF_RATE 32'h0000_001C

`define ST_BUSY 0
`define ST_RX_AVAIL 1
`define ST_TX_FULL 2
`define ST_RX_FULL 3
`define ST_TX_EMPTY 4

`define CTRL_BREAK 0
`define CTRL_SRC_OSC 1

`define FMT_LEN_LSB 0
`define FMT_STOP2 2
`define FMT_PAR_LSB 3

`define EV_RX_CHAR 0
`define EV_TX_DONE 1
`define EV_RX_OVERRUN 2
`define EV_RX_ERROR 3

`define CHAR_LEN_FIVE 2'h0
`define CHAR_LEN_SIX 2'h1
`define CHAR_LEN_SEVEN 2'h2
`define CHAR_LEN_EIGHT 2'h3

`define PARITY_OFF 3'h0
`define PARITY_EVEN_SEL 3'h1
`define PARITY_ODD_SEL 3'h2
`define PARITY_FORCED_HIGH 3'h3
`define PARITY_FORCED_LOW 3'h4

`define FIFO_DEPTH 16
`define OVERSAMPLE_LAST 4'hF
`define SAMPLE_MID 4'h7
`define SYS_CLK_HZ 32'd100000000
`define INTERNAL_OSC_HZ 32'd16000000
`define DIVISOR_RESET 16'h0001
`define FORMAT_RESET 6'h03

`endif

// >>> core/uart_frame_config_status.sv
// Serial transceiver core with Wishbone registers, queues, frame format and baud source select
// Summary of operation
// (R1) Break control set holds the line low; cleared returns to idle or framing.
// (R2) Software keeps break set at least two whole frames.
// (R3) Busy while anything queued or shifting, until last stop bit has left.
// (R4) Status bit shows receive queue holds at least one character.
// (R5) Reading receive data pops and returns the oldest character.
// (R6) Status bit shows transmit queue full; writes queue only while space remains.
// (R7) Software writes a character only when the transmit queue has space.
// (R8) Baud source selects system clock or internal oscillator, readable back.
// (R9) Internal oscillator is nominally sixteen megahertz for divisor arithmetic.
// (R10) Bit rate follows the selected source for an unchanged divisor.
// (R11) Software reprograms the divisor after changing the baud source.
// (R12) Character length five to eight bits for transmit and receive.
// (R13) One or two stop bits after each character.
// (R14) Parity none, even, odd, forced one or forced zero.
// (R15) Readback reports the effective bit rate from divisor and source clock.
// (R16) Frame format reads back in the same encoding as written.
// (R17) System clock source is the same clock as the processor clock.
// (R18) Frame: low start, data LSB first, optional parity, high stop bits.
`timescale 1ns/10ps
`include "uart_consts.svh"

module uart_frame_config_status
    import uart_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire wb_req_type wb_i,
    output logic ack_o,
    output logic [31:0] dat_o,
    output logic irq_o,
    input wire logic osc_tick_i,
    input wire logic rx_i,
    output logic tx_o
);

    state_type s;
    state_type n;

    // Data bits actually on the line, masked to the character length
    function automatic logic [7:0] len_mask(input logic [1:0] len);
        len_mask = 8'hFF >> (2'h3 - len);
    endfunction

    function automatic logic par_bit(input logic [7:0] d, input logic [1:0] len,
                                     input logic [2:0] mode);
        logic x;
        x = ^(d & len_mask(len));
        case (mode)
            `PARITY_EVEN_SEL: par_bit = x;
            `PARITY_ODD_SEL: par_bit = ~x;
            `PARITY_FORCED_HIGH: par_bit = 1'b1;
            default: par_bit = 1'b0;
        endcase
    endfunction

    // Received bits enter at the top; short characters must be moved down
    function automatic logic [7:0] align(input logic [7:0] sh, input logic [1:0] len);
        align = sh >> (2'h3 - len);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = sel[b] ? d[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    function automatic logic [15:0] eff_div(input logic [15:0] d);
        eff_div = (d == 16'h0000) ? 16'h0001 : d;
    endfunction

    always_comb begin
        logic src_tick;
        logic bit_end;
        logic tx_pop;
        logic tx_push;
        logic rx_pop;
        logic rx_push;
        logic rd_clear;
        logic restart;
        logic [3:0] ev;
        logic [7:0] rx_byte;
        logic [31:0] r_tmp;
        logic [31:0] dd;
        logic [31:0] w;
        logic [1:0] len;
        logic [2:0] last_bit;
        src_tick = 1'b0;
        bit_end = 1'b0;
        tx_pop = 1'b0;
        tx_push = 1'b0;
        rx_pop = 1'b0;
        rx_push = 1'b0;
        rd_clear = 1'b0;
        restart = 1'b0;
        ev = 4'h0;
        rx_byte = 8'h00;
        r_tmp = 32'h0000_0000;
        dd = 32'h0000_0000;
        w = 32'h0000_0000;
        len = s.fmt[`FMT_LEN_LSB +: 2];
        last_bit = {1'b1, len};
        n = s;
        n.ack = 1'b0;

        // Source clock edge: every system clock, or one oscillator strobe
        src_tick = s.src_osc ? osc_tick_i : 1'b1; // (R10) (R17)
        n.tick = 1'b0;
        if (src_tick) begin
            if (s.bcnt == 16'h0000) begin
                n.bcnt = 16'(eff_div(s.div) - 16'h0001);
                n.tick = 1'b1;
            end else begin
                n.bcnt = s.bcnt - 16'h0001;
            end
        end

        // Transmitter, sixteen ticks per bit
        bit_end = s.tick && (s.tx_sub == `OVERSAMPLE_LAST);
        if (s.tick && s.tx_st != TX_IDLE) begin
            n.tx_sub = s.tx_sub + 4'h1;
        end
        unique case (s.tx_st)
            TX_IDLE: begin
                // No new character starts while break is held
                if (s.tx_cnt != 5'd0 && !s.brk) begin // (R1)
                    tx_pop = 1'b1;
                    n.tx_sh = s.txq[s.tx_rp];
                    n.tx_par = par_bit(s.txq[s.tx_rp], len, s.fmt[`FMT_PAR_LSB +: 3]);
                    n.tx_st = TX_START;
                    n.tx_sub = 4'h0;
                    n.tx_line = 1'b0; // (R18)
                end
            end
            TX_START: begin
                if (bit_end) begin
                    n.tx_st = TX_DATA;
                    n.tx_bit = 3'h0;
                    n.tx_line = s.tx_sh[0]; // (R18)
                end
            end
            TX_DATA: begin
                if (bit_end) begin
                    if (s.tx_bit == last_bit) begin // (R12)
                        if (s.fmt[`FMT_PAR_LSB +: 3] != `PARITY_OFF) begin // (R14)
                            n.tx_st = TX_PAR;
                            n.tx_line = s.tx_par;
                        end else begin
                            n.tx_st = TX_STOP;
                            n.tx_line = 1'b1;
                        end
                        n.tx_bit = 3'h0;
                    end else begin
                        n.tx_bit = s.tx_bit + 3'h1;
                        n.tx_sh = s.tx_sh >> 1;
                        n.tx_line = s.tx_sh[1];
                    end
                end
            end
            TX_PAR: begin
                if (bit_end) begin
                    n.tx_st = TX_STOP;
                    n.tx_line = 1'b1;
                end
            end
            TX_STOP: begin
                if (bit_end) begin
                    if (s.fmt[`FMT_STOP2] && s.tx_bit == 3'h0) begin // (R13)
                        n.tx_bit = 3'h1;
                    end else begin
                        n.tx_st = TX_IDLE;
                        ev[`EV_TX_DONE] = (s.tx_cnt == 5'd0);
                    end
                end
            end
        endcase

        // Receiver: start checked at mid bit, later bits sampled one bit apart
        if (s.tick && s.rx_st != RX_IDLE) begin
            n.rx_sub = s.rx_sub + 4'h1;
        end
        rx_byte = align(s.rx_sh, len);
        unique case (s.rx_st)
            RX_IDLE: begin
                if (!rx_i) begin
                    n.rx_st = RX_START;
                    n.rx_sub = 4'h0;
                    n.rx_bad = 1'b0;
                end
            end
            RX_START: begin
                if (s.tick && s.rx_sub == `SAMPLE_MID) begin
                    n.rx_sub = 4'h0;
                    n.rx_bit = 3'h0;
                    n.rx_st = rx_i ? RX_IDLE : RX_DATA; // (R18)
                end
            end
            RX_DATA: begin
                if (s.tick && s.rx_sub == `OVERSAMPLE_LAST) begin
                    n.rx_sh = {rx_i, s.rx_sh[7:1]};
                    if (s.rx_bit == last_bit) begin // (R12)
                        n.rx_st = (s.fmt[`FMT_PAR_LSB +: 3] != `PARITY_OFF) ? RX_PAR : RX_STOP;
                    end else begin
                        n.rx_bit = s.rx_bit + 3'h1;
                    end
                end
            end
            RX_PAR: begin
                if (s.tick && s.rx_sub == `OVERSAMPLE_LAST) begin
                    n.rx_bad = (rx_i != par_bit(rx_byte, len, s.fmt[`FMT_PAR_LSB +: 3])); // (R14)
                    n.rx_st = RX_STOP;
                end
            end
            RX_STOP: begin
                // Only the first stop bit is checked so back-to-back frames are not missed
                if (s.tick && s.rx_sub == `OVERSAMPLE_LAST) begin
                    n.rx_st = RX_IDLE;
                    ev[`EV_RX_ERROR] = s.rx_bad || !rx_i;
                    if (s.rx_cnt == 5'(`FIFO_DEPTH)) begin
                        ev[`EV_RX_OVERRUN] = 1'b1;
                    end else begin
                        rx_push = 1'b1;
                        ev[`EV_RX_CHAR] = 1'b1;
                    end
                end
            end
        endcase
        if (rx_push) begin
            n.rxq[s.rx_wp] = rx_byte;
            n.rx_wp = s.rx_wp + 4'h1;
        end

        // Wishbone classic slave: one access answered per request
        if (wb_i.cyc && wb_i.stb && !s.ack) begin
            n.ack = 1'b1;
            n.rdat = 32'h0000_0000;
            unique case (wb_i.adr)
                `OFF_DATA: begin
                    if (wb_i.we) begin
                        if (wb_i.sel[0] && s.tx_cnt != 5'(`FIFO_DEPTH)) begin // (R6)
                            tx_push = 1'b1;
                        end
                    end else if (s.rx_cnt != 5'd0) begin
                        rx_pop = 1'b1; // (R5)
                        n.rdat = {24'h000000, s.rxq[s.rx_rp]};
                    end
                end
                `OFF_STATUS: begin
                    n.rdat[`ST_BUSY] = (s.tx_cnt != 5'd0) || (s.tx_st != TX_IDLE); // (R3)
                    n.rdat[`ST_RX_AVAIL] = (s.rx_cnt != 5'd0); // (R4)
                    n.rdat[`ST_TX_FULL] = (s.tx_cnt == 5'(`FIFO_DEPTH)); // (R6)
                    n.rdat[`ST_RX_FULL] = (s.rx_cnt == 5'(`FIFO_DEPTH));
                    n.rdat[`ST_TX_EMPTY] = (s.tx_cnt == 5'd0);
                end
                `OFF_CTRL: begin
                    w = merge({30'h0, s.src_osc, s.brk}, wb_i.dat, wb_i.sel);
                    if (wb_i.we) begin
                        n.brk = w[`CTRL_BREAK]; // (R1)
                        n.src_osc = w[`CTRL_SRC_OSC]; // (R8)
                        restart = 1'b1;
                    end
                    n.rdat = {30'h0, s.src_osc, s.brk}; // (R8)
                end
                `OFF_FORMAT: begin
                    w = merge({26'h0, s.fmt}, wb_i.dat, wb_i.sel);
                    if (wb_i.we) begin
                        n.fmt = w[5:0];
                    end
                    n.rdat = {26'h0, s.fmt}; // (R16)
                end
                `OFF_DIVISOR: begin
                    w = merge({16'h0, s.div}, wb_i.dat, wb_i.sel);
                    if (wb_i.we) begin
                        n.div = w[15:0];
                        restart = 1'b1;
                    end
                    n.rdat = {16'h0, s.div};
                end
                `OFF_INT_STATUS: begin
                    rd_clear = !wb_i.we;
                    n.rdat = {28'h0, s.int_st};
                end
                `OFF_INT_MASK: begin
                    w = merge({28'h0, s.int_mask}, wb_i.dat, wb_i.sel);
                    if (wb_i.we) begin
                        n.int_mask = w[3:0];
                    end
                    n.rdat = {28'h0, s.int_mask};
                end
                `OFF_RATE: begin
                    n.rdat = s.rate; // (R15)
                end
                default: begin
                    n.rdat = 32'h0000_0000;
                end
            endcase
        end

        if (tx_push) begin
            n.txq[s.tx_wp] = wb_i.dat[7:0];
            n.tx_wp = s.tx_wp + 4'h1;
        end
        if (tx_pop) begin
            n.tx_rp = s.tx_rp + 4'h1;
        end
        if (rx_pop) begin
            n.rx_rp = s.rx_rp + 4'h1;
        end
        n.tx_cnt = 5'(s.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop});
        n.rx_cnt = 5'(s.rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop});

        // Line drives break level whatever the shifter is doing
        n.tx_pin = n.brk ? 1'b0 : n.tx_line; // (R1)

        // Effective rate = source Hz / (16 * divisor), by serial division
        dd = {12'h000, eff_div(s.div), 4'h0};
        if (restart) begin
            n.rate_n = n.src_osc ? `INTERNAL_OSC_HZ : `SYS_CLK_HZ; // (R9) (R15)
            n.rate_r = 32'h0000_0000;
            n.rate_i = 5'd0;
            n.rate_busy = 1'b1;
        end else if (s.rate_busy) begin
            r_tmp = {s.rate_r[30:0], s.rate_n[31]};
            n.rate_n = {s.rate_n[30:0], 1'b0};
            if (r_tmp >= dd) begin
                r_tmp = r_tmp - dd;
                n.rate_n[0] = 1'b1;
            end
            n.rate_r = r_tmp;
            n.rate_i = s.rate_i + 5'd1;
            if (s.rate_i == 5'd31) begin
                n.rate_busy = 1'b0;
                n.rate = n.rate_n; // (R15)
            end
        end

        // A new event in the clearing read's cycle survives the clear
        n.int_st = (rd_clear ? 4'h0 : s.int_st) | ev;
        n.irq = |(n.int_st & n.int_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.fmt <= `FORMAT_RESET;
            s.div <= `DIVISOR_RESET;
            s.tx_st <= TX_IDLE;
            s.rx_st <= RX_IDLE;
            s.tx_line <= 1'b1;
            s.tx_pin <= 1'b1;
            s.rate_n <= `SYS_CLK_HZ;
            s.rate_busy <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign ack_o = s.ack;
    assign dat_o = s.rdat;
    assign irq_o = s.irq;
    assign tx_o = s.tx_pin;

endmodule

// >>> core/uart_pkg.sv
// Types shared by the serial core: bus request, state machine codes and the state record
`include "uart_consts.svh"

package uart_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [31:0] adr;
        logic [31:0] dat;
    } wb_req_type;

    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA = 5'b00100,
        TX_PAR = 5'b01000,
        TX_STOP = 5'b10000
    } tx_state_type;

    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA = 5'b00100,
        RX_PAR = 5'b01000,
        RX_STOP = 5'b10000
    } rx_state_type;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic brk;
        logic src_osc;
        logic [5:0] fmt;
        logic [15:0] div;
        logic [3:0] int_st;
        logic [3:0] int_mask;
        logic irq;
        logic [`FIFO_DEPTH-1:0][7:0] txq;
        logic [3:0] tx_wp;
        logic [3:0] tx_rp;
        logic [4:0] tx_cnt;
        logic [`FIFO_DEPTH-1:0][7:0] rxq;
        logic [3:0] rx_wp;
        logic [3:0] rx_rp;
        logic [4:0] rx_cnt;
        logic [15:0] bcnt;
        logic tick;
        tx_state_type tx_st;
        logic [3:0] tx_sub;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic tx_line;
        logic tx_pin;
        rx_state_type rx_st;
        logic [3:0] rx_sub;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_bad;
        logic [31:0] rate_n;
        logic [31:0] rate_r;
        logic [4:0] rate_i;
        logic rate_busy;
        logic [31:0] rate;
    } state_type;

endpackage

// >>> tb/uart_frame_config_status_asserts.sv
// Port-level checker for the serial core
`timescale 1ns/10ps
`include "uart_consts.svh"
module uart_frame_config_status_asserts
    import uart_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire wb_req_type wb_i,
    input wire logic ack_o,
    input wire logic [31:0] dat_o,
    input wire logic irq_o,
    input wire logic osc_tick_i,
    input wire logic rx_i,
    input wire logic tx_o
);
    logic brk_reg;
    logic src_reg;
    logic [5:0] fmt_reg;
    logic wr_ok;
    logic rd_ok;
    // Shadows take a write at the edge where the core takes it, so they never lag the line
    assign wr_ok = !ack_o && wb_i.cyc && wb_i.stb && wb_i.we && wb_i.sel[0];
    assign rd_ok = ack_o && wb_i.cyc && wb_i.stb && !wb_i.we;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            brk_reg <= 1'b0;
            src_reg <= 1'b0;
            fmt_reg <= `FORMAT_RESET;
        end else if (wr_ok && wb_i.adr == `OFF_CTRL) begin
            brk_reg <= wb_i.dat[`CTRL_BREAK];
            src_reg <= wb_i.dat[`CTRL_SRC_OSC];
        end else if (wr_ok && wb_i.adr == `OFF_FORMAT) begin
            fmt_reg <= wb_i.dat[5:0];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_next: assert property (wb_i.cyc && wb_i.stb && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    a_break_low: assert property (brk_reg |-> !tx_o)
        else $error("line not held low in break");
    a_bit_width: assert property ($changed(tx_o) && !brk_reg && !$past(brk_reg)
        |=> $stable(tx_o) [*8]) else $error("line bit too short");
    a_busy_shown: assert property (rd_ok && wb_i.adr == `OFF_STATUS && !tx_o && !brk_reg
        && !$past(brk_reg) |-> dat_o[`ST_BUSY]) else $error("idle shown during a frame");
    a_fmt_back: assert property (rd_ok && wb_i.adr == `OFF_FORMAT
        |-> dat_o[5:0] == fmt_reg) else $error("format readback differs");
    a_ctrl_back: assert property (rd_ok && wb_i.adr == `OFF_CTRL
        |-> dat_o[1:0] == {src_reg, brk_reg}) else $error("control readback differs");
    a_unmapped_zero: assert property (rd_ok && wb_i.adr >= 32'h0000_0020 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind uart_frame_config_status uart_frame_config_status_asserts chk (.clk_i(clk_i),
    .rst_i(rst_i), .wb_i(wb_i), .ack_o(ack_o), .dat_o(dat_o), .irq_o(irq_o),
    .osc_tick_i(osc_tick_i), .rx_i(rx_i), .tx_o(tx_o));

// >>> tb/uart_frame_config_status_tb.sv
// Self-checking bench for the serial core
`timescale 1ns/10ps
`include "uart_consts.svh"
module uart_frame_config_status_tb
    import uart_pkg::*;
;
    logic clk_i;
    logic rst_i;
    wb_req_type wb_i;
    logic ack_o;
    logic [31:0] dat_o;
    logic irq_o;
    logic osc_tick_i;
    logic rx_i;
    logic tx_o;
    int error_cnt;
    int samples_checked;
    int cycles;
    int osc_cnt;
    logic [31:0] v;
    logic [11:0] got;
    int n;
    uart_frame_config_status dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .ack_o(ack_o),
        .dat_o(dat_o), .irq_o(irq_o), .osc_tick_i(osc_tick_i), .rx_i(rx_i), .tx_o(tx_o));
    uart_remote_node remote (.clk_i(clk_i), .line_i(tx_o), .line_o(rx_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Oscillator strobe every 6 cycles keeps bit times whole numbers of clocks
    always @(posedge clk_i) begin
        osc_cnt <= (osc_cnt == 5) ? 0 : osc_cnt + 1;
        osc_tick_i <= (osc_cnt == 5);
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge clk_i);
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o;
        wb_i.cyc <= 1'b0;
        wb_i.stb <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] j;
        wb(1'b1, a, d, j);
    endtask
    task automatic rd(input logic [31:0] a);
        wb(1'b0, a, 32'h0, v);
    endtask
    function automatic logic [11:0] frame(input logic [7:0] d, input int len, input int par,
                                          input logic two, output int k);
        logic [11:0] f;
        logic p;
        f = 12'hFFF;
        f[0] = 1'b0;
        p = ^(d & 8'((1 << (len + 5)) - 1));
        for (int i = 0; i < len + 5; i++) f[i + 1] = d[i];
        k = len + 6;
        if (par != 0) begin
            f[k] = (par == 1) ? p : (par == 2) ? !p : (par == 3);
            k++;
        end
        k = k + (two ? 2 : 1);
        return f;
    endfunction
    task automatic t_reset();
        rd(`OFF_FORMAT);
        chk(v, 32'(`FORMAT_RESET));
        rd(`OFF_DIVISOR);
        chk(v, 32'(`DIVISOR_RESET));
        rd(`OFF_STATUS);
        chk(v, 32'h0000_0010);
        rd(32'h0000_0040);
        chk(v, 32'h0);
        repeat (40) @(posedge clk_i);
        rd(`OFF_RATE);
        chk(v, `SYS_CLK_HZ / 32'd16);
        $display("reset test done");
    endtask
    task automatic t_formats();
        logic [11:0] e;
        logic [7:0] d;
        logic [31:0] fm;
        for (int len = 0; len < 4; len++) begin
            for (int par = 0; par < 5; par++) begin
                d = 8'hA5 ^ 8'(len * 7 + par * 3);
                e = frame(d, len, par, par[0], n);
                fm = 32'(len) | 32'(par[0]) << `FMT_STOP2 | 32'(par) << `FMT_PAR_LSB;
                wr(`OFF_FORMAT, fm);
                rd(`OFF_FORMAT);
                chk(v, fm);
                fork
                    remote.recv(n, 16, got);
                    begin
                        wr(`OFF_DATA, 32'(d));
                        rd(`OFF_STATUS);
                        chk(32'(v[`ST_BUSY]), 32'h1);
                    end
                join
                chk(32'(got), 32'(e));
                rd(`OFF_STATUS);
                chk(32'(v[`ST_BUSY]), 32'h1);
                repeat (16) @(posedge clk_i);
                rd(`OFF_STATUS);
                chk(32'(v[`ST_BUSY]), 32'h0);
                remote.send(e, n, 16);
                rd(`OFF_STATUS);
                chk(32'(v[`ST_RX_AVAIL]), 32'h1);
                rd(`OFF_DATA);
                chk(v, 32'(d & 8'((1 << (len + 5)) - 1)));
            end
        end
        $display("format test done");
    endtask
    task automatic t_fifo();
        wr(`OFF_FORMAT, 32'(`FORMAT_RESET));
        wr(`OFF_CTRL, 32'h1);
        for (int i = 0; i < `FIFO_DEPTH; i++) begin
            rd(`OFF_STATUS);
            chk(32'(v[`ST_TX_FULL]), 32'h0);
            wr(`OFF_DATA, 32'(8'h30 + 8'(i)));
        end
        rd(`OFF_STATUS);
        chk(32'(v[`ST_TX_FULL]), 32'h1);
        wr(`OFF_DATA, 32'h5A);
        // Break kept for two whole eight-bit one-stop frames
        repeat (2 * 10 * 16) begin
            @(posedge clk_i);
            chk(32'(tx_o), 32'h0);
        end
        wr(`OFF_CTRL, 32'h0);
        for (int i = 0; i < `FIFO_DEPTH; i++) begin
            remote.recv(10, 16, got);
            chk(32'(got), 32'(frame(8'h30 + 8'(i), 3, 0, 1'b0, n)));
        end
        // Short wait: a wrongly queued seventeenth character would still be shifting
        repeat (24) @(posedge clk_i);
        rd(`OFF_STATUS);
        chk(v & 32'h15, 32'h10);
        $display("queue test done");
    endtask
    task automatic t_rx();
        wr(`OFF_INT_MASK, 32'h0);
        rd(`OFF_INT_STATUS);
        for (int i = 0; i < 3; i++) remote.send(frame(8'hC0 + 8'(i), 3, 0, 1'b0, n), 10, 16);
        repeat (4) @(posedge clk_i);
        chk(32'(irq_o), 32'h0);
        wr(`OFF_INT_MASK, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(32'(irq_o), 32'h1);
        for (int i = 0; i < 3; i++) begin
            rd(`OFF_DATA);
            chk(v, 32'hC0 + 32'(i));
        end
        rd(`OFF_STATUS);
        chk(32'(v[`ST_RX_AVAIL]), 32'h0);
        rd(`OFF_DATA);
        chk(v, 32'h0);
        rd(`OFF_INT_STATUS);
        chk(v, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(32'(irq_o), 32'h0);
        $display("receive test done");
    endtask
    task automatic t_source();
        wr(`OFF_CTRL, 32'h2);
        rd(`OFF_CTRL);
        chk(v, 32'h2);
        repeat (40) @(posedge clk_i);
        rd(`OFF_RATE);
        chk(v, `INTERNAL_OSC_HZ / 32'd16);
        wr(`OFF_DIVISOR, 32'h2);
        repeat (40) @(posedge clk_i);
        rd(`OFF_RATE);
        chk(v, `INTERNAL_OSC_HZ / 32'd32);
        fork
            remote.recv(10, 192, got);
            wr(`OFF_DATA, 32'h96);
        join
        chk(32'(got), 32'(frame(8'h96, 3, 0, 1'b0, n)));
        repeat (200) @(posedge clk_i);
        rd(`OFF_INT_STATUS);
        chk(v, 32'h2);
        wr(`OFF_CTRL, 32'h0);
        wr(`OFF_DIVISOR, 32'h1);
        repeat (40) @(posedge clk_i);
        rd(`OFF_RATE);
        chk(v, `SYS_CLK_HZ / 32'd16);
        $display("source test done");
    endtask
    initial begin
        rst_i = 1'b1;
        wb_i = '0;
        osc_tick_i = 1'b0;
        osc_cnt = 0;
        cycles = 0;
        error_cnt = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_formats();
        t_fifo();
        t_rx();
        t_source();
        conclude();
    end
endmodule

// >>> tb/uart_remote_node.sv
// Remote serial node: sends frames to the core and captures frames from it
`timescale 1ns/10ps
module uart_remote_node (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    initial line_o = 1'b1;
    task automatic send(input logic [11:0] bits, input int n, input int bt);
        @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            line_o <= bits[i];
            repeat (bt) @(posedge clk_i);
        end
        line_o <= 1'b1;
    endtask
    // Returns at the middle of the last bit; waits for idle first so break is not a start
    task automatic recv(input int n, input int bt, output logic [11:0] bits);
        int w;
        bits = 12'hFFF;
        w = 0;
        while (line_i !== 1'b1 && w < 9000) begin
            @(posedge clk_i);
            w++;
        end
        while (line_i !== 1'b0 && w < 9000) begin
            @(posedge clk_i);
            w++;
        end
        repeat (bt / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            bits[i] = line_i;
            if (i < n - 1) repeat (bt) @(posedge clk_i);
        end
    endtask
endmodule
